// File: rtl/sdpi_host.sv
// Purpose: Controller end: issues one command at a time on the pins.
// Assumes: Write data waits in an 8-word buffer before a write starts.
// Notes:   Idle cycles carry a deselect so nothing stray is taken.
`timescale 1ns/1ps
module sdpi_fifo #(
    parameter int W = 36,
    parameter int D = 8
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [$clog2(D+1)-1:0] count
);
    localparam int CW = $clog2(D+1);
    localparam int PW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          push;
    logic          pop;

    assign push    = in_valid && in_ready;
    assign pop     = out_valid && out_ready;
    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

    // Pointers, count and registered full and empty flags.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wp_r      <= '0;
            rp_r      <= '0;
            cnt_r     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp_r      <= wp_r + PW'(push);
            rp_r      <= rp_r + PW'(pop);
            cnt_r     <= cnt_nxt;
            in_ready  <= cnt_nxt != CW'(D);
            out_valid <= cnt_nxt != '0;
        end
    end

    // Storage write.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    assign out_data = mem[rp_r];
    assign count    = cnt_r;
endmodule // sdpi_fifo

module sdpi_host (
    input  wire logic        clock,
    input  wire logic        rst,
    sdpi_if.host             pins,
    input  wire logic        cke_req,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [2:0]  req_cmd,
    input  wire logic [1:0]  req_bank,
    input  wire logic [10:0] req_addr,
    input  wire logic [3:0]  req_mask,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  wr_mask,
    output logic             rd_valid,
    output logic [31:0]      rd_data
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1, H_WAIT = 4'h2, H_WR = 4'h4, H_RD = 4'h8
    } sdpi_hst_t;

    sdpi_hst_t    st_r;
    sdpi_hst_t    st_nxt;
    logic [2:0]   cmd_h_r;
    logic [1:0]   bank_h_r;
    logic [10:0]  addr_h_r;
    logic [3:0]   mask_h_r;
    logic [10:0]  mode_h_r;
    logic [8:0]   beats;
    logic [8:0]   cnt_r;
    logic         issue;
    logic         pop;
    logic         f_valid;
    logic [35:0]  f_data;
    logic [3:0]   f_cnt;
    logic         cke_r;
    logic         cs_n_r;
    logic [2:0]   strb_r;
    logic [1:0]   bank_r;
    logic [10:0]  addr_r;
    logic [3:0]   bm_r;
    logic [31:0]  dq_r;
    logic [3:0]   oe_n_r;
    logic         rdy_r;
    logic         rdv_r;
    logic [31:0]  rdd_r;

    sdpi_fifo #(.W(sdpi_pkg::FIFO_W), .D(sdpi_pkg::FIFO_D)) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_mask, wr_data}),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data),
        .count     (f_cnt)
    );

    assign beats = {1'b0, sdpi_pkg::sdpi_bmask(
                       mode_h_r[sdpi_pkg::BL_LSB +: 3])} + 9'h001;
    // A write goes out only once its whole burst sits in the buffer.
    assign issue = st_r == H_WAIT && cke_r &&
                   (cmd_h_r != sdpi_pkg::CMD_WR || {5'h00, f_cnt} >= beats);
    assign pop   = f_valid && ((issue && cmd_h_r == sdpi_pkg::CMD_WR) ||
                               st_r == H_WR);

    // Next state of the request sequencer.
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            H_IDLE: if (req_valid && rdy_r) st_nxt = H_WAIT;
            H_WAIT: if (issue) begin
                if (cmd_h_r == sdpi_pkg::CMD_RD) st_nxt = H_RD;
                else if (cmd_h_r == sdpi_pkg::CMD_WR && beats != 9'h001)
                    st_nxt = H_WR;
                else st_nxt = H_IDLE;
            end
            H_WR, H_RD: if (cnt_r == 9'h001) st_nxt = H_IDLE;
        endcase
    end

    // Request hold, counters, mode copy and ready.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r     <= H_IDLE;
            cmd_h_r  <= sdpi_pkg::CMD_NOP;
            bank_h_r <= 2'h0;
            addr_h_r <= 11'h000;
            mask_h_r <= 4'h0;
            mode_h_r <= sdpi_pkg::MODE_RST;
            cnt_r    <= 9'h000;
            rdy_r    <= 1'b0;
            cke_r    <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cke_r <= cke_req;
            rdy_r <= st_nxt == H_IDLE && cke_req;
            if (st_r == H_IDLE && req_valid && rdy_r) begin
                cmd_h_r  <= req_cmd;
                bank_h_r <= req_bank;
                addr_h_r <= req_addr;
                mask_h_r <= req_mask;
            end
            if (issue) begin
                if (cmd_h_r == sdpi_pkg::CMD_LMR) mode_h_r <= addr_h_r;
                cnt_r <= cmd_h_r == sdpi_pkg::CMD_RD ?
                    beats + 9'(mode_h_r[sdpi_pkg::CL_LSB +: 3]) :
                    beats - 9'h001;
            end else if (st_r == H_WR || st_r == H_RD) begin
                cnt_r <= cnt_r - 9'h001;
            end
        end
    end

    // Pin drive: deselect by default, data and mask with write beats.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_n_r <= 1'b1;
            strb_r <= 3'h7;
            bank_r <= 2'h0;
            addr_r <= 11'h000;
            bm_r   <= 4'h0;
            dq_r   <= 32'h0000_0000;
            oe_n_r <= 4'hf;
            rdv_r  <= 1'b0;
            rdd_r  <= 32'h0000_0000;
        end else begin
            cs_n_r <= !issue;
            strb_r <= issue ? cmd_h_r : 3'h7;
            oe_n_r <= pop ? 4'h0 : 4'hf;
            dq_r   <= f_data[31:0];
            if (issue) begin
                bank_r <= bank_h_r;
                addr_r <= addr_h_r;
            end
            if (pop) begin
                bm_r <= f_data[35:32];
            end else if (issue && cmd_h_r == sdpi_pkg::CMD_RD) begin
                bm_r <= mask_h_r;
            end else if (st_nxt != H_RD) begin
                bm_r <= 4'h0;
            end
            rdv_r <= st_r == H_RD && cnt_r <= beats;
            rdd_r <= pins.data_lines;
        end
    end

    assign pins.cke        = cke_r;
    assign pins.cs_n       = cs_n_r;
    assign {pins.ras_n, pins.cas_n, pins.we_n} = strb_r;
    assign pins.bank_sel   = bank_r;
    assign pins.addr_lines = addr_r;
    assign pins.byte_mask  = bm_r;
    assign pins.h_dq_o     = dq_r;
    assign pins.h_dq_oe_n  = oe_n_r;
    assign req_ready       = rdy_r;
    assign rd_valid        = rdv_r;
    assign rd_data         = rdd_r;
endmodule // sdpi_host

// File: rtl/sdpi_pkg.sv
// Purpose: Shared constants and types for the DRAM pin command interface.
// Assumes: Four banks, eleven address lines, 32 data lines in four lanes.
// Notes:   Command codes are the row, column and write strobe levels.
package sdpi_pkg;
    localparam int AW        = 11;     // Address lines.
    localparam int BW        = 2;      // Bank select lines.
    localparam int DW        = 32;     // Data lines.
    localparam int NLANE     = 4;      // Byte lanes.
    localparam int LANE      = 8;      // Bits per lane.
    localparam int A_HI      = 10;     // Auto-close and all-banks line.
    localparam int COL_W     = 8;      // Column field width.
    localparam int BL_LSB    = 0;      // Burst length field of the mode word.
    localparam int CL_LSB    = 4;      // Read latency field of the mode word.
    localparam logic [10:0] MODE_RST = 11'h030;
    localparam logic [2:0]  CL_THREE = 3'h3;
    localparam int MEM_ROW_B = 2;      // Row bits kept by the array model.
    localparam int MEM_COL_B = 4;      // Column bits kept by the array model.
    localparam int MEM_AW    = BW + MEM_ROW_B + MEM_COL_B;
    localparam int FIFO_W    = DW + NLANE;
    localparam int FIFO_D    = 8;

    // Strobe levels {row, column, write}, all active low.
    typedef enum logic [2:0] {
        CMD_LMR = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
        CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
    } sdpi_cmd_t;

    // Beats after the first one, as a column wrap mask.
    function automatic logic [7:0] sdpi_bmask(input logic [2:0] bl);
        case (bl)
            3'h1:    sdpi_bmask = 8'h01;
            3'h2:    sdpi_bmask = 8'h03;
            3'h3:    sdpi_bmask = 8'h07;
            3'h7:    sdpi_bmask = 8'hff;
            default: sdpi_bmask = 8'h00;
        endcase
    endfunction
endpackage

// File: rtl/sdpi_if.sv
// Purpose: Pin bundle between the memory controller and the DRAM end.
// Assumes: Each end drives a byte lane only while its enable is low.
// Notes:   The shared data wire is resolved here from both enables.
`timescale 1ns/1ps
interface sdpi_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank_sel;
    logic [10:0] addr_lines;
    logic [3:0]  byte_mask;
    logic [31:0] h_dq_o;
    logic [3:0]  h_dq_oe_n;
    logic [31:0] d_dq_o;
    logic [3:0]  d_dq_oe_n;
    wire  [31:0] data_lines;

    // Each lane carries whichever end enables it.
    // A lane that no end enables reads as zero, standing in for a float.
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign data_lines[i*8 +: 8] = !h_dq_oe_n[i] ? h_dq_o[i*8 +: 8] :
                                      !d_dq_oe_n[i] ? d_dq_o[i*8 +: 8] :
                                      8'h00;
    end

    modport host (output cke, cs_n, ras_n, cas_n, we_n, bank_sel,
                  addr_lines, byte_mask, h_dq_o, h_dq_oe_n,
                  input data_lines);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_sel,
                 addr_lines, byte_mask, data_lines,
                 output d_dq_o, d_dq_oe_n);
endinterface

// File: rtl/sdpi_dev.sv
// Purpose: DRAM end of the pin interface: decode, banks, bursts, masks.
// Assumes: A small array stands for the cells; clock is 40 MHz.
// Notes:   The clock-gate pin is synchronised, so it acts two edges late.
`timescale 1ns/1ps
// How it works
// - Row-open stores all address lines as row.
// - Low column lines start burst; top line auto-closes.
// - Bank close: top line high closes all.
// - Mode load takes op-code from address lines.
// - Bank select picks one of four banks.
// - Three strobes together form the command.
// - Edges count only while clock gate high.
// - Gate low means power-down, suspend or self refresh.
// - Clock gate is asynchronous; others sampled on edge.
// - Chip select high ignores commands, keeps state.
// - Each mask bit governs one byte lane.
// - Masked read lanes float.
// - Masked write lanes keep stored data.
// - Read mask leads its beat by two clocks.
// - Write mask aligns with its data beat.
module sdpi_dev (
    input  wire logic   clock,
    input  wire logic   rst,
    sdpi_if.dev         pins,
    output logic [3:0]  bank_open,
    output logic [2:0]  power_mode,
    output logic [10:0] mode_word
);
    typedef enum logic [3:0] {
        PW_RUN  = 4'h1,
        PW_PDN  = 4'h2,
        PW_SUSP = 4'h4,
        PW_SREF = 4'h8
    } sdpi_pw_t;

    logic                  cke_s1_r;
    logic                  cke_s2_r;
    logic                  en;
    sdpi_pkg::sdpi_cmd_t   cmd;
    sdpi_pw_t              pw_r;
    logic [10:0]           mode_r;
    logic [3:0]            open_r;
    logic [10:0]           row_r [4];
    logic                  last_ref_r;
    logic                  brd_r;
    logic                  bwr_r;
    logic [1:0]            bbank_r;
    logic [7:0]            bcol_r;
    logic [7:0]            bleft_r;
    logic                  bap_r;
    logic                  cur_rd;
    logic                  cur_wr;
    logic                  cur_new;
    logic [1:0]            cur_bank;
    logic [7:0]            cur_col;
    logic                  cur_ap;
    logic                  last_beat;
    logic [7:0]            bmask;
    logic [7:0]            col_nxt;
    logic [sdpi_pkg::MEM_AW-1:0] idx;
    logic [31:0]           mem [2**sdpi_pkg::MEM_AW];
    logic [1:0]            pv_r;
    logic [31:0]           pd_r [2];
    logic [3:0]            mask_q_r;
    logic [31:0]           dq_o_r;
    logic [3:0]            oe_n_r;
    logic                  cl3;

    // Clock gate comes in untimed, so it passes two flops first.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cke_s1_r <= 1'b0;
            cke_s2_r <= 1'b0;
        end else begin
            cke_s1_r <= pins.cke;
            cke_s2_r <= cke_s1_r;
        end
    end
    assign en = cke_s2_r;

    // Command from the strobes; a deselected chip sees a no-op.
    assign cmd = pins.cs_n ? sdpi_pkg::CMD_NOP :
        sdpi_pkg::sdpi_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});

    assign bmask = sdpi_pkg::sdpi_bmask(mode_r[sdpi_pkg::BL_LSB +: 3]);
    assign cl3   = mode_r[sdpi_pkg::CL_LSB +: 3] == sdpi_pkg::CL_THREE;

    // Beat of this edge: a new read or write, or the running burst.
    always_comb begin
        cur_new  = 1'b0;
        cur_rd   = 1'b0;
        cur_wr   = 1'b0;
        cur_bank = bbank_r;
        cur_col  = bcol_r;
        cur_ap   = bap_r;
        if ((cmd == sdpi_pkg::CMD_RD || cmd == sdpi_pkg::CMD_WR) &&
            open_r[pins.bank_sel]) begin
            cur_new  = 1'b1;
            cur_rd   = cmd == sdpi_pkg::CMD_RD;
            cur_wr   = cmd == sdpi_pkg::CMD_WR;
            cur_bank = pins.bank_sel;
            cur_col  = pins.addr_lines[sdpi_pkg::COL_W-1:0];
            cur_ap   = pins.addr_lines[sdpi_pkg::A_HI];
        end else if (cmd != sdpi_pkg::CMD_BST) begin
            cur_rd = brd_r;
            cur_wr = bwr_r;
        end
    end
    assign last_beat = (cur_rd || cur_wr) &&
                       (cur_new ? bmask == 8'h00 : bleft_r == 8'h01);
    assign col_nxt = (cur_col & ~bmask) | ((cur_col + 8'h01) & bmask);
    assign idx = {cur_bank, row_r[cur_bank][sdpi_pkg::MEM_ROW_B-1:0],
                  cur_col[sdpi_pkg::MEM_COL_B-1:0]};

    // Burst tracking: remaining beats, column wrap, auto-close flag.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            brd_r   <= 1'b0;
            bwr_r   <= 1'b0;
            bbank_r <= 2'h0;
            bcol_r  <= 8'h00;
            bleft_r <= 8'h00;
            bap_r   <= 1'b0;
        end else if (en) begin
            bbank_r <= cur_bank;
            bcol_r  <= col_nxt;
            bap_r   <= cur_ap;
            bleft_r <= cur_new ? bmask : bleft_r - 8'h01;
            brd_r   <= cur_rd && !last_beat;
            bwr_r   <= cur_wr && !last_beat;
        end
    end

    // Bank rows: open, close one or all, close after an auto burst.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            open_r <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                row_r[b] <= 11'h000;
            end
        end else if (en) begin
            if (cmd == sdpi_pkg::CMD_ACT) begin
                open_r[pins.bank_sel] <= 1'b1;
                row_r[pins.bank_sel]  <= pins.addr_lines;
            end else if (cmd == sdpi_pkg::CMD_PRE) begin
                if (pins.addr_lines[sdpi_pkg::A_HI]) begin
                    open_r <= 4'h0;
                end else begin
                    open_r[pins.bank_sel] <= 1'b0;
                end
            end else if (last_beat && cur_ap) begin
                open_r[cur_bank] <= 1'b0;
            end
        end
    end

    // Mode word loads only while every bank is closed.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r     <= sdpi_pkg::MODE_RST;
            last_ref_r <= 1'b0;
        end else if (en) begin
            if (cmd == sdpi_pkg::CMD_LMR && open_r == 4'h0) begin
                mode_r <= pins.addr_lines;
            end
            // A deselected edge is no command, so the last one is kept.
            if (!pins.cs_n) begin
                last_ref_r <= cmd == sdpi_pkg::CMD_REF;
            end
        end
    end

    // Write beats store only the lanes whose mask is low this edge.
    always_ff @(posedge clock) begin
        if (en && cur_wr) begin
            for (int l = 0; l < sdpi_pkg::NLANE; l++) begin
                if (!pins.byte_mask[l]) begin
                    mem[idx][l*8 +: 8] <= pins.data_lines[l*8 +: 8];
                end
            end
        end
    end

    // Read pipe; the lane enable uses the mask from two edges before.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pv_r     <= 2'h0;
            pd_r[0]  <= 32'h0000_0000;
            pd_r[1]  <= 32'h0000_0000;
            mask_q_r <= 4'hf;
            dq_o_r   <= 32'h0000_0000;
            oe_n_r   <= 4'hf;
        end else if (en) begin
            pv_r     <= {pv_r[0], cur_rd};
            pd_r[0]  <= mem[idx];
            pd_r[1]  <= pd_r[0];
            mask_q_r <= pins.byte_mask;
            dq_o_r   <= cl3 ? pd_r[1] : pd_r[0];
            if (cl3 ? pv_r[1] : pv_r[0]) begin
                oe_n_r <= mask_q_r;
            end else begin
                oe_n_r <= 4'hf;
            end
        end
    end

    // Low-power state while the gate is low, picked on its fall.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pw_r <= PW_RUN;
        end else if (en) begin
            pw_r <= PW_RUN;
        end else if (pw_r == PW_RUN) begin
            if (brd_r || bwr_r || pv_r != 2'h0) begin
                pw_r <= PW_SUSP;
            end else if (last_ref_r) begin
                pw_r <= PW_SREF;
            end else begin
                pw_r <= PW_PDN;
            end
        end
    end

    assign pins.d_dq_o    = dq_o_r;
    assign pins.d_dq_oe_n = oe_n_r;
    assign bank_open      = open_r;
    assign power_mode     = pw_r[3:1];
    assign mode_word      = mode_r;
endmodule // sdpi_dev

// File: tb/sdpi_assertions.sv
// Purpose: Pin checks between the controller end and the DRAM end.
// Assumes: Mode word keeps read latency 3 throughout the run.
// Notes:   Sees the interface signals only, so checks are pin relations.
`timescale 1ns/1ps
module sdpi_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       cke,
    input wire logic       cs_n,
    input wire logic       ras_n,
    input wire logic       cas_n,
    input wire logic       we_n,
    input wire logic [3:0] byte_mask,
    input wire logic [3:0] h_dq_oe_n,
    input wire logic [3:0] d_dq_oe_n
);
    // ----------------------------------------
    // Command shapes
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // A read or write command as seen on the strobes.
    sequence s_rd_cmd;
        !cs_n && ras_n && !cas_n && we_n;
    endsequence
    sequence s_wr_cmd;
        !cs_n && ras_n && !cas_n && !we_n;
    endsequence
    sequence s_mask_held;
        $stable(byte_mask) [*3];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_cmd_one_cycle: assert property (!cs_n |=> cs_n)
        else $error("command held longer than one cycle");
    a_cmd_gate_high: assert property (!cs_n |-> cke)
        else $error("command issued with clock gate low");
    a_lane_no_fight: assert property (((~h_dq_oe_n) & (~d_dq_oe_n)) == 4'h0)
        else $error("both ends drive one lane");
    a_wr_host_drive: assert property (s_wr_cmd |-> h_dq_oe_n == 4'h0)
        else $error("write data not driven with command");
    a_wr_dev_quiet: assert property (s_wr_cmd |-> d_dq_oe_n == 4'hf)
        else $error("device drives during write");
    a_rd_first_beat: assert property (s_rd_cmd ##0 (byte_mask != 4'hf)
        |-> ##3 (d_dq_oe_n == byte_mask))
        else $error("read beat lanes wrong at latency");
    a_rd_mask_lead: assert property ((d_dq_oe_n != 4'hf)
        |-> (d_dq_oe_n == $past(byte_mask, 2)))
        else $error("read lane enable not from mask two clocks back");
    a_rd_mask_hold: assert property (s_rd_cmd |=> s_mask_held)
        else $error("read mask moved during read");
    c_read: cover property (s_rd_cmd);
endmodule // sdpi_checker

// File: tb/sdram_pin_command_interface_bench.sv
// Purpose: Drives the controller end against the DRAM end and judges both.
// Assumes: 40 MHz clock, reset held five cycles.
// Notes:   Read beats are gathered into a queue as they arrive.
`timescale 1ns/1ps
module sdram_pin_command_interface_bench;
    logic        clock = 1'b0;
    logic        rst;
    logic        cke_req;
    logic        req_valid;
    logic        req_ready;
    logic [2:0]  req_cmd;
    logic [1:0]  req_bank;
    logic [10:0] req_addr;
    logic [3:0]  req_mask;
    logic        wr_valid;
    logic        wr_ready;
    logic [31:0] wr_data;
    logic [3:0]  wr_mask;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic [3:0]  bank_open;
    logic [2:0]  power_mode;
    logic [10:0] mode_word;
    logic [31:0] rd_q[$];
    int          num_errors = 0;
    int          check_count = 0;

    // ----------------------------------------
    // Ends, pins and checker
    // ----------------------------------------
    sdpi_if pins ();
    sdpi_host i_sdpi_host (.clock(clock), .rst(rst), .pins(pins),
        .cke_req(cke_req), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_mask(req_mask), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_mask(wr_mask), .rd_valid(rd_valid),
        .rd_data(rd_data));
    sdpi_dev i_sdpi_dev (.clock(clock), .rst(rst), .pins(pins),
        .bank_open(bank_open), .power_mode(power_mode),
        .mode_word(mode_word));
    sdpi_checker i_sdpi_checker (.clock(clock), .rst(rst), .cke(pins.cke),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
        .we_n(pins.we_n), .byte_mask(pins.byte_mask),
        .h_dq_oe_n(pins.h_dq_oe_n), .d_dq_oe_n(pins.d_dq_oe_n));

    // Clock toggles every half period of 12.5 ns.
    always #12.5 clock = ~clock;

    // Gathers each returned read beat.
    always @(posedge clock) begin
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Issues one request and waits until the controller is idle again.
    task automatic cmd(input sdpi_pkg::sdpi_cmd_t c, input logic [1:0] b,
                       input logic [10:0] a, input logic [3:0] m);
        int n;
        n = 0;
        req_cmd   <= c;
        req_bank  <= b;
        req_addr  <= a;
        req_mask  <= m;
        req_valid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 99);
        req_valid <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 99);
        // The DRAM end takes the command on this edge; let it settle.
        @(posedge clock);
        check(n < 99, "request did not finish");
    endtask

    // Pushes eight words; beat one carries mask m1; then expects refusal.
    task automatic fill(input logic [31:0] base, input logic [3:0] m1);
        for (int k = 0; k < 8; k++) begin
            check(wr_ready === 1'b1, "buffer refused early");
            wr_data  <= base + k;
            wr_mask  <= (k == 1) ? m1 : 4'h0;
            wr_valid <= 1'b1;
            @(posedge clock);
        end
        wr_valid <= 1'b0;
        wait_cyc(2);
        check(wr_ready === 1'b0, "full buffer still ready");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_setup();
        check(mode_word === 11'h030 && bank_open === 4'h0, "reset state");
        cmd(sdpi_pkg::CMD_LMR, 2'h0, 11'h033, 4'h0);
        check(mode_word === 11'h033, "mode load");
        cmd(sdpi_pkg::CMD_ACT, 2'h2, 11'h005, 4'h0);
        cmd(sdpi_pkg::CMD_ACT, 2'h1, 11'h7fd, 4'h0);
        wait_cyc(8);
        check(bank_open === 4'h6, "row open per bank");
        $display("test_setup done");
    endtask

    task automatic test_write();
        fill(32'h1234_5640, 4'h0);
        cmd(sdpi_pkg::CMD_WR, 2'h2, 11'h000, 4'h0);
        check(wr_ready === 1'b1, "buffer not drained");
        fill(32'h9abc_de80, 4'h1);
        cmd(sdpi_pkg::CMD_WR, 2'h2, 11'h000, 4'h0);
        cmd(sdpi_pkg::CMD_PRE, 2'h1, 11'h000, 4'h0);
        check(bank_open === 4'h4, "single bank close");
        $display("test_write done");
    endtask

    // Reads back with lane one masked and auto-close set.
    task automatic test_read();
        logic [31:0] exp;
        rd_q.delete();
        cmd(sdpi_pkg::CMD_RD, 2'h2, 11'h400, 4'h2);
        wait_cyc(4);
        check(rd_q.size() == 8, "read beat count");
        for (int k = 0; k < 8; k++) begin
            exp = (k == 1) ? 32'h9abc_de41 : 32'h9abc_de80 + k;
            check(rd_q[k] === (exp & 32'hffff_00ff), "read data");
        end
        check(bank_open === 4'h0, "auto close after read");
        cmd(sdpi_pkg::CMD_ACT, 2'h0, 11'h001, 4'h0);
        cmd(sdpi_pkg::CMD_ACT, 2'h3, 11'h002, 4'h0);
        cmd(sdpi_pkg::CMD_PRE, 2'h0, 11'h400, 4'h0);
        check(bank_open === 4'h0, "all banks close");
        $display("test_read done");
    endtask

    task automatic test_power();
        cke_req <= 1'b0;
        wait_cyc(6);
        check(power_mode === 3'h1, "power-down");
        check(req_ready === 1'b0, "gate low accepts requests");
        cke_req <= 1'b1;
        wait_cyc(6);
        check(power_mode === 3'h0, "run after gate high");
        cmd(sdpi_pkg::CMD_REF, 2'h0, 11'h000, 4'h0);
        cke_req <= 1'b0;
        wait_cyc(6);
        check(power_mode === 3'h4, "self refresh");
        cke_req <= 1'b1;
        wait_cyc(6);
        $display("test_power done");
    endtask

    // Watchdog cuts a hang short.
    initial begin
        #(25 * 20000);
        check(1'b0, "watchdog expired");
        give_verdict();
    end

    // Main sequence.
    initial begin
        rst       = 1'b1;
        cke_req   = 1'b1;
        req_valid = 1'b0;
        req_cmd   = 3'h7;
        req_bank  = 2'h0;
        req_addr  = 11'h000;
        req_mask  = 4'h0;
        wr_valid  = 1'b0;
        wr_data   = 32'h0000_0000;
        wr_mask   = 4'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        wait_cyc(6);
        test_setup();
        test_write();
        test_read();
        test_power();
        give_verdict();
    end
endmodule // sdram_pin_command_interface_bench
